// file: ums_pkg.sv
// constants shared by the modem and line status block
package ums_pkg;

	// ------------------------------------------------------------
	// register map: index of each register, byte address = index * 4
	// ------------------------------------------------------------
	localparam int         UMS_AW             = 5;
	localparam logic [2:0] UMS_IDX_RX_HOLD    = 3'h0;
	localparam logic [2:0] UMS_IDX_MODEM_CTRL = 3'h4;
	localparam logic [2:0] UMS_IDX_LINE       = 3'h5;
	localparam logic [2:0] UMS_IDX_MODEM      = 3'h6;

	localparam logic [UMS_AW-1:0] UMS_ADDR_RX_HOLD    = {UMS_IDX_RX_HOLD, 2'b00};
	localparam logic [UMS_AW-1:0] UMS_ADDR_MODEM_CTRL = {UMS_IDX_MODEM_CTRL, 2'b00};
	localparam logic [UMS_AW-1:0] UMS_ADDR_LINE       = {UMS_IDX_LINE, 2'b00};
	localparam logic [UMS_AW-1:0] UMS_ADDR_MODEM      = {UMS_IDX_MODEM, 2'b00};

	// ------------------------------------------------------------
	// modem control field layout and reset value
	// ------------------------------------------------------------
	localparam int         UMS_MC_W       = 5;
	localparam int         UMS_MC_DTR     = 0;
	localparam int         UMS_MC_RTS     = 1;
	localparam int         UMS_MC_OUT_ONE = 2;
	localparam int         UMS_MC_OUT_TWO = 3;
	localparam int         UMS_MC_LOOP    = 4;
	localparam logic [4:0] UMS_MC_RST     = 5'h00;

	// ------------------------------------------------------------
	// line status and modem status bit positions
	// ------------------------------------------------------------
	localparam int UMS_LS_READY    = 0;
	localparam int UMS_LS_OVERRUN  = 1;
	localparam int UMS_MS_CTS_CHG  = 0;
	localparam int UMS_MS_DSR_CHG  = 1;
	localparam int UMS_MS_RI_EDGE  = 2;
	localparam int UMS_MS_DCD_CHG  = 3;
	localparam int UMS_MS_CTS      = 4;
	localparam int UMS_MS_DSR      = 5;
	localparam int UMS_MS_RI       = 6;
	localparam int UMS_MS_DCD      = 7;
	localparam int UMS_LVL_CTS     = 0;
	localparam int UMS_LVL_DSR     = 1;
	localparam int UMS_LVL_RI      = 2;
	localparam int UMS_LVL_DCD     = 3;

	// ------------------------------------------------------------
	// misc reset values, depth and bus answers
	// ------------------------------------------------------------
	localparam logic [3:0] UMS_PIN_RST    = 4'hf;
	localparam logic [3:0] UMS_FLAG_RST   = 4'h0;
	localparam int         UMS_RX_DEPTH   = 16;
	localparam logic [1:0] UMS_RESP_OKAY  = 2'h0;
	localparam logic [1:0] UMS_RESP_SLVERR = 2'h2;

endpackage

// file: ums_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module ums_sync import ums_pkg::*; #(
	parameter int         WIDTH   = 4,
	parameter logic [3:0] RST_VAL = UMS_PIN_RST
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_r
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					meta_r[i] <= RST_VAL[i];
					sync_r[i] <= RST_VAL[i];
				end else begin
					meta_r[i] <= async_in[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule // ums_sync

// file: ums_delta.sv
// sticky change indicators of the four modem status levels
`timescale 1ns/100ps
module ums_delta import ums_pkg::*; (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] level,
	input  wire logic       clr,
	output logic      [3:0] flag_r
);

	logic [3:0] prev_r;
	logic       arm_r;
	logic [3:0] evt;

	// first cycle after reset only loads the history, no false change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_r <= UMS_FLAG_RST;
			arm_r  <= 1'b0;
		end else begin
			prev_r <= level;
			arm_r  <= 1'b1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_flag
			// ring flag wants the pin going low to high: level falls
			if (i == UMS_LVL_RI) begin : g_edge
				assign evt[i] = arm_r && prev_r[i] && !level[i]; // see RULE12
			end else begin : g_any
				assign evt[i] = arm_r && (prev_r[i] != level[i]); // see RULE4
			end
			// set beats the clearing read
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					flag_r[i] <= UMS_FLAG_RST[i];
				end else if (evt[i]) begin
					flag_r[i] <= 1'b1; // see RULE15
				end else if (clr) begin
					flag_r[i] <= 1'b0; // see RULE5
				end
			end
		end
	endgenerate

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_flag_set: assert property (|evt |=> (flag_r & $past(evt)) == $past(evt)) // see RULE4
		else $error("change flag not set after level change");
	chk_read_clear: assert property (clr && !(|evt) |=> flag_r == UMS_FLAG_RST) // see RULE5
		else $error("change flags not cleared by status read");
	chk_set_wins: assert property (clr && |evt |=> |flag_r) // see RULE15
		else $error("change lost in clearing read cycle");

endmodule // ums_delta

// file: ums_modem_line_status.sv
// modem status and receive line status registers behind an axi4-lite slave
//
// Function
// RULE1 - overrun flag set at overrun stop bit
// RULE2 - data ready set when character stored
// RULE3 - data ready clears after all characters read
// RULE4 - change bits set on modem input change
// RULE5 - modem status read clears change bits
// RULE6 - bit7 inverted carrier, loopback: user output two
// RULE7 - bit6 inverted ring, loopback: user output one
// RULE8 - bit5 inverted set-ready, loopback: dtr bit
// RULE9 - bit4 inverted clear-to-send, loopback: rts bit
// RULE10 - bit3 flags carrier level change since read
// RULE11 - any change bit raises modem interrupt
// RULE12 - bit2 flags ring pin low-to-high
// RULE13 - bit0 flags clear-to-send change since read
// RULE14 - bit1 flags set-ready change since read
// RULE15 - synchronise inputs; set beats clearing read
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module ums_modem_line_status import ums_pkg::*; #(
	parameter int RX_DEPTH = UMS_RX_DEPTH
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [UMS_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [UMS_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              rx_push,
	input  wire logic [7:0]        rx_data,
	input  wire logic              rx_overrun_evt,
	output logic                   rx_pop,
	output logic                   rx_data_ready,
	input  wire logic              cts_n,
	input  wire logic              dsr_n,
	input  wire logic              ri_n,
	input  wire logic              dcd_n,
	output logic                   rts_n,
	output logic                   dtr_n,
	output logic                   user_output_one_n,
	output logic                   user_output_two_n,
	output logic                   modem_irq
);

	localparam int CNT_W = $clog2(RX_DEPTH + 1);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic                awready_r;
	logic                wready_r;
	logic                bvalid_r;
	logic [1:0]          bresp_r;
	logic                arready_r;
	logic                rvalid_r;
	logic [31:0]         rdata_r;
	logic [1:0]          rresp_r;
	logic                aw_got_r;
	logic                w_got_r;
	logic [UMS_AW-1:0]   aw_addr_r;
	logic [7:0]          w_byte_r;
	logic                w_lane_r;
	logic [UMS_MC_W-1:0] modem_control_reg_r;
	logic [CNT_W-1:0]    rx_cnt_r;
	logic [CNT_W-1:0]    rx_cnt_nxt;
	logic                rx_ready_r;
	logic                rx_pop_r;
	logic                overrun_r;
	logic                modem_irq_r;
	logic                rts_n_r;
	logic                dtr_n_r;
	logic                out_one_n_r;
	logic                out_two_n_r;
	logic [3:0]          pin_s;
	logic [3:0]          status_cur;
	logic [3:0]          delta_r;
	logic [31:0]         rd_word;
	logic                rd_ok;
	logic                aw_hs;
	logic                w_hs;
	logic                ar_hs;
	logic                wr_fire;
	logic                rd_modem;
	logic                rd_line;
	logic                rd_pop;
	logic                mode_loop;

	assign aw_hs    = s_axi_awvalid && awready_r;
	assign w_hs     = s_axi_wvalid && wready_r;
	assign ar_hs    = s_axi_arvalid && arready_r;
	assign wr_fire  = aw_got_r && w_got_r && !bvalid_r;
	assign rd_modem = ar_hs && (s_axi_araddr == UMS_ADDR_MODEM);
	assign rd_line  = ar_hs && (s_axi_araddr == UMS_ADDR_LINE);
	assign rd_pop   = ar_hs && (s_axi_araddr == UMS_ADDR_RX_HOLD) && (rx_cnt_r != '0);
	assign mode_loop = modem_control_reg_r[UMS_MC_LOOP];

	// ------------------------------------------------------------
	// write channels: address and data taken in either order
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
		end else if (aw_hs) begin
			awready_r <= 1'b0;
		end else if (!aw_got_r && !bvalid_r) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b0;
		end else if (w_hs) begin
			wready_r <= 1'b0;
		end else if (!w_got_r && !bvalid_r) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			aw_addr_r <= '0;
		end else if (aw_hs) begin
			aw_got_r  <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_got_r  <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_r  <= 1'b0;
			w_byte_r <= '0;
			w_lane_r <= 1'b0;
		end else if (w_hs) begin
			w_got_r  <= 1'b1;
			w_byte_r <= s_axi_wdata[7:0];
			w_lane_r <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_got_r  <= 1'b0;
		end
	end

	// read-only and holding offsets accept writes silently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= UMS_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			case (aw_addr_r)
				UMS_ADDR_RX_HOLD, UMS_ADDR_MODEM_CTRL,
				UMS_ADDR_LINE, UMS_ADDR_MODEM: bresp_r <= UMS_RESP_OKAY;
				default: bresp_r <= UMS_RESP_SLVERR;
			endcase
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modem_control_reg_r <= UMS_MC_RST;
		end else if (wr_fire && w_lane_r && aw_addr_r == UMS_ADDR_MODEM_CTRL) begin
			modem_control_reg_r <= w_byte_r[UMS_MC_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// read channel: data and side effects at the address edge
	// ------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
			UMS_ADDR_RX_HOLD:    rd_word = 32'(rx_data);
			UMS_ADDR_MODEM_CTRL: rd_word = 32'(modem_control_reg_r);
			UMS_ADDR_LINE:       rd_word = 32'({overrun_r, rx_ready_r});
			UMS_ADDR_MODEM:      rd_word = 32'({status_cur, delta_r}); // see RULE10
			default:             rd_ok   = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
		end else if (ar_hs) begin
			arready_r <= 1'b0;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= UMS_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_ok ? UMS_RESP_OKAY : UMS_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// receive line status
	// ------------------------------------------------------------
	// a push into a full store is the receiver's overrun, not counted
	always_comb begin
		rx_cnt_nxt = rx_cnt_r;
		if (rx_push && (rx_cnt_r != CNT_W'(RX_DEPTH) || rd_pop)) begin
			rx_cnt_nxt = rx_cnt_nxt + 1'b1;
		end
		if (rd_pop) begin
			rx_cnt_nxt = rx_cnt_nxt - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt_r   <= '0;
			rx_ready_r <= 1'b0;
			rx_pop_r   <= 1'b0;
		end else begin
			rx_cnt_r   <= rx_cnt_nxt;
			rx_ready_r <= (rx_cnt_nxt != '0); // see RULE2 see RULE3
			rx_pop_r   <= rd_pop;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun_r <= 1'b0;
		end else if (rx_overrun_evt) begin
			overrun_r <= 1'b1; // see RULE1
		end else if (rd_line) begin
			overrun_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// modem status
	// ------------------------------------------------------------
	ums_sync #(
		.WIDTH   (4),
		.RST_VAL (UMS_PIN_RST)
	) u_pin_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({dcd_n, ri_n, dsr_n, cts_n}), // see RULE15
		.sync_r   (pin_s)
	);

	// loopback takes the levels from the control bits instead of the pins
	always_comb begin
		if (mode_loop) begin
			status_cur[UMS_LVL_DCD] = modem_control_reg_r[UMS_MC_OUT_TWO]; // see RULE6
			status_cur[UMS_LVL_RI]  = modem_control_reg_r[UMS_MC_OUT_ONE]; // see RULE7
			status_cur[UMS_LVL_DSR] = modem_control_reg_r[UMS_MC_DTR]; // see RULE8
			status_cur[UMS_LVL_CTS] = modem_control_reg_r[UMS_MC_RTS]; // see RULE9
		end else begin
			status_cur = ~pin_s; // see RULE6 see RULE7 see RULE8 see RULE9
		end
	end

	ums_delta u_delta (
		.aclk    (aclk),
		.aresetn (aresetn),
		.level   (status_cur), // see RULE13 see RULE14
		.clr     (rd_modem), // see RULE5
		.flag_r  (delta_r)
	);

	// outputs idle high in loopback so the modem sees nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			modem_irq_r <= 1'b0;
			rts_n_r     <= 1'b1;
			dtr_n_r     <= 1'b1;
			out_one_n_r <= 1'b1;
			out_two_n_r <= 1'b1;
		end else begin
			modem_irq_r <= |delta_r; // see RULE11
			rts_n_r     <= mode_loop || !modem_control_reg_r[UMS_MC_RTS];
			dtr_n_r     <= mode_loop || !modem_control_reg_r[UMS_MC_DTR];
			out_one_n_r <= mode_loop || !modem_control_reg_r[UMS_MC_OUT_ONE];
			out_two_n_r <= mode_loop || !modem_control_reg_r[UMS_MC_OUT_TWO];
		end
	end

	assign s_axi_awready     = awready_r;
	assign s_axi_wready      = wready_r;
	assign s_axi_bvalid      = bvalid_r;
	assign s_axi_bresp       = bresp_r;
	assign s_axi_arready     = arready_r;
	assign s_axi_rvalid      = rvalid_r;
	assign s_axi_rdata       = rdata_r;
	assign s_axi_rresp       = rresp_r;
	assign rx_pop            = rx_pop_r;
	assign rx_data_ready     = rx_ready_r;
	assign modem_irq         = modem_irq_r;
	assign rts_n             = rts_n_r;
	assign dtr_n             = dtr_n_r;
	assign user_output_one_n = out_one_n_r;
	assign user_output_two_n = out_two_n_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_overrun_set: assert property ( // see RULE1
		rx_overrun_evt |=> overrun_r)
		else $error("overrun flag not set");
	chk_overrun_clear: assert property ( // see RULE1
		rd_line && !rx_overrun_evt |=> !overrun_r)
		else $error("overrun flag not cleared by line status read");
	chk_ready_set: assert property ( // see RULE2
		rx_push |=> rx_ready_r)
		else $error("data ready not set after push");
	chk_ready_fall: assert property ( // see RULE3
		$fell(rx_ready_r) |-> $past(rd_pop) && $past(rx_cnt_r) == CNT_W'(1))
		else $error("data ready cleared while characters remain");
	chk_carrier_loop: assert property ( // see RULE6
		rd_modem && mode_loop
		|=> s_axi_rdata[UMS_MS_DCD] == $past(modem_control_reg_r[UMS_MC_OUT_TWO]))
		else $error("carrier status wrong in loopback");
	chk_ring_level: assert property ( // see RULE7
		!mode_loop && $past(aresetn) && $past(aresetn, 2)
		|-> status_cur[UMS_LVL_RI] == !$past(ri_n, 2))
		else $error("ring status not inverted pin");
	chk_set_ready_loop: assert property ( // see RULE8
		rd_modem && mode_loop
		|=> s_axi_rdata[UMS_MS_DSR] == $past(modem_control_reg_r[UMS_MC_DTR]))
		else $error("set-ready status wrong in loopback");
	chk_cts_level: assert property ( // see RULE9
		!mode_loop && $past(aresetn) && $past(aresetn, 2)
		|-> status_cur[UMS_LVL_CTS] == !$past(cts_n, 2))
		else $error("clear-to-send status not inverted pin");
	chk_carrier_change: assert property ( // see RULE10
		$past(aresetn) && $changed(status_cur[UMS_LVL_DCD]) |=> delta_r[UMS_MS_DCD_CHG])
		else $error("carrier change not flagged");
	chk_irq_raise: assert property ( // see RULE11
		|delta_r[UMS_MS_DCD_CHG:UMS_MS_CTS_CHG] |=> modem_irq_r)
		else $error("modem interrupt not raised");
	chk_ring_edge: assert property ( // see RULE12
		$past(aresetn) && $fell(status_cur[UMS_LVL_RI]) |=> delta_r[UMS_MS_RI_EDGE])
		else $error("ring trailing edge not flagged");
	chk_cts_change: assert property ( // see RULE13
		$past(aresetn) && $changed(status_cur[UMS_LVL_CTS]) |=> delta_r[UMS_MS_CTS_CHG])
		else $error("clear-to-send change not flagged");
	chk_dsr_change: assert property ( // see RULE14
		$past(aresetn) && $changed(status_cur[UMS_LVL_DSR]) |=> delta_r[UMS_MS_DSR_CHG])
		else $error("set-ready change not flagged");
	chk_sync_depth: assert property ( // see RULE15
		!mode_loop && $past(aresetn) && $past(aresetn, 2)
		|-> status_cur[UMS_LVL_DCD] == !$past(dcd_n, 2))
		else $error("carrier input not two-flop synchronised");

	cov_modem_read_flag: cover property (rd_modem && |delta_r);
	cov_overrun_read:    cover property (rx_overrun_evt ##[1:20] rd_line);
	cov_drain:           cover property ($fell(rx_ready_r));
	cov_loop_change:     cover property (mode_loop && $changed(status_cur));

endmodule // ums_modem_line_status

// file: ums_modem_model.sv
// modem side model: drives the four active-low control pins
`timescale 1ns/100ps
module ums_modem_model (
	input  wire logic [3:0] want,
	output logic      [3:0] pins
);
	// pins move between clock edges, unrelated to the channel clock
	initial pins = 4'hf;
	always @(want) pins <= #3 want;
endmodule // ums_modem_model

// file: ums_modem_line_status_tb_top.sv
// testbench for the modem and line status block
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ums_modem_line_status_tb_top import ums_pkg::*;;
	logic        aclk, aresetn;
	logic [4:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, p, pins;
	logic [1:0]  bresp, rresp, r;
	logic        rx_push, rx_ovr, rx_pop, rdy, irq;
	logic        rts_n, dtr_n, uo1_n, uo2_n;
	logic [7:0]  rxd;
	int          num_errors, check_count, cyc, i, pops;
	logic [3:0]  lb_exp [4] = '{4'h2, 4'h1, 4'h4, 4'h8};

	ums_modem_line_status u_ums_modem_line_status (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_push(rx_push),
		.rx_data(rxd), .rx_overrun_evt(rx_ovr), .rx_pop(rx_pop), .rx_data_ready(rdy),
		.cts_n(pins[0]), .dsr_n(pins[1]), .ri_n(pins[2]), .dcd_n(pins[3]),
		.rts_n(rts_n), .dtr_n(dtr_n), .user_output_one_n(uo1_n),
		.user_output_two_n(uo2_n), .modem_irq(irq));
	ums_modem_model u_ums_modem_model (.want(p), .pins(pins));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// -------------------------------------------------------------
	// bus tasks and closing
	// -------------------------------------------------------------
	task automatic axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic settle();
		// covers two sync flops, flag and irq stages with margin
		repeat (8) @(posedge aclk);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// pop pulses counted mid-cycle, where the output has settled
	always @(negedge aclk) begin
		if (rx_pop === 1'b1) pops++;
	end

	// -------------------------------------------------------------
	// test sequence
	// -------------------------------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, rx_push, rx_ovr} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		rxd = 8'h5a;
		p = 4'hf;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		axr(UMS_ADDR_MODEM, d, r);
		`CHK(d, 32'h0)
		axr(UMS_ADDR_LINE, d, r);
		`CHK(d, 32'h0)
		$display("reset values done");

		for (i = 0; i < 4; i++) begin
			p[i] <= 1'b0;
			settle();
			`CHK(irq, (i != 2))
			axr(UMS_ADDR_MODEM, d, r);
			`CHK(d[7:0], {~p, 4'h0} | (i == 2 ? 8'h00 : 8'h01 << i))
			axr(UMS_ADDR_MODEM, d, r);
			`CHK(d[7:0], {~p, 4'h0})
			settle();
			`CHK(irq, 1'b0)
			p[i] <= 1'b1;
			settle();
			axr(UMS_ADDR_MODEM, d, r);
			`CHK(d[7:0], 8'h01 << i)
		end
		$display("modem pins done");

		for (i = 0; i < 4; i++) begin
			axw(UMS_ADDR_MODEM_CTRL, 32'h10 | (32'h1 << i), r);
			settle();
			axr(UMS_ADDR_MODEM, d, r);
			`CHK(d[7:4], lb_exp[i])
			`CHK({uo2_n, uo1_n, rts_n, dtr_n}, 4'hf)
		end
		axw(UMS_ADDR_MODEM_CTRL, 32'h03, r);
		settle();
		axr(UMS_ADDR_MODEM, d, r);
		`CHK(d[7:4], 4'h0)
		`CHK({uo2_n, uo1_n, rts_n, dtr_n}, 4'hc)
		axr(UMS_ADDR_MODEM_CTRL, d, r);
		`CHK(d, 32'h03)
		wstrb <= 4'he;
		axw(UMS_ADDR_MODEM_CTRL, 32'h1c, r);
		`CHK(r, UMS_RESP_OKAY)
		wstrb <= 4'hf;
		axr(UMS_ADDR_MODEM_CTRL, d, r);
		`CHK(d, 32'h03)
		$display("loopback done");

		@(posedge aclk);
		rx_push <= 1'b1;
		repeat (2) @(posedge aclk);
		rx_push <= 1'b0;
		@(posedge aclk);
		`CHK(rdy, 1'b1)
		axr(UMS_ADDR_LINE, d, r);
		`CHK(d, 32'h01)
		axr(UMS_ADDR_RX_HOLD, d, r);
		`CHK(d, 32'h5a)
		@(posedge aclk);
		`CHK(rdy, 1'b1)
		axr(UMS_ADDR_RX_HOLD, d, r);
		@(posedge aclk);
		`CHK(rdy, 1'b0)
		`CHK(pops, 2)
		axr(UMS_ADDR_LINE, d, r);
		`CHK(d, 32'h00)
		rx_ovr <= 1'b1;
		@(posedge aclk);
		rx_ovr <= 1'b0;
		axr(UMS_ADDR_LINE, d, r);
		`CHK(d, 32'h02)
		axr(UMS_ADDR_LINE, d, r);
		`CHK(d, 32'h00)
		$display("receive status done");

		axw(5'h08, 32'h1, r);
		`CHK(r, UMS_RESP_SLVERR)
		axr(5'h1c, d, r);
		`CHK(r, UMS_RESP_SLVERR)
		`CHK(d, 32'h0)
		$display("unmapped access done");
		give_verdict();
	end
endmodule // ums_modem_line_status_tb_top
